//--- host_port.sv
`timescale 1ns/100ps
// How it works
// - Capture address on configured latch strobe
// - Drive ports only on read with block selected
// - Forward port addresses to logic arrays
// - First control as active-low write strobe
// - First control as read/write direction flag
// - First control as low-byte write strobe
// - First and second controls into logic arrays
// - Second control: read, enable clock, data strobe
// - Split mode: second control strobes low byte
// - Third control marks code-fetch cycles
// - Third control: high enable or high strobe
// - Third control: size enable or low strobe
// - Third control always into logic arrays
// - Reset low initialises ports, cells, registers
// - Reset aborts flash program or erase
// - Pin functions fixed by stored configuration
// - Address strobe captures on rising edge
// - Chip select gates memory access
// - Optional high-byte write strobe input
module host_port
    import host_port_pkg::*;
#(
    parameter int DATA_W = BUS_W
)
(
    input wire logic clk_in,                              // 20 MHz system clock
    input wire logic sys_rst_in,                          // Synchronous reset, high
    input wire logic reset_n_in,                          // Device reset pin, low
    input wire host_mode_t cfg_host_mode_in,              // Stored: controls one/two
    input wire third_mode_t cfg_third_mode_in,            // Stored: control three
    input wire logic cfg_bus16_in,                        // Stored: 16-bit data bus
    input wire logic cfg_edge_latch_in,                   // Stored: strobe on edge
    input wire logic cfg_cs_used_in,                      // Stored: chip select in use
    input wire logic cfg_high_write_used_in,              // Stored: high write pin in use
    input wire logic [BYTE_W-1:0] lower_addr_data_port_in,  // Lower port level
    output logic [BYTE_W-1:0] lower_addr_data_port_out,     // Lower port drive
    output logic lower_addr_data_port_oe_n_out,             // Low while driving
    input wire logic [BYTE_W-1:0] upper_addr_data_port_in,  // Upper port level
    output logic [BYTE_W-1:0] upper_addr_data_port_out,     // Upper port drive
    output logic upper_addr_data_port_oe_n_out,             // Low while driving
    input wire logic control_input_first_in,              // First control pin
    input wire logic control_input_second_in,             // Second control pin
    input wire logic control_input_third_in,              // Third control pin
    input wire logic address_strobe_in,                   // Address latch strobe
    input wire logic chip_select_n_in,                    // Chip select, low
    input wire logic high_byte_write_n_in,                // High-byte write, low
    input wire logic block_selected_in,                   // Any internal block decoded
    input wire logic [DATA_W-1:0] read_data_in,           // Data from selected block
    output logic [DATA_W-1:0] latched_addr_out,           // Held address
    output logic [DATA_W-1:0] pla_addr_out,               // Port address to arrays
    output logic [CTRL_W-1:0] pla_ctrl_out,               // Controls to arrays
    output logic [DATA_W-1:0] write_data_out,             // Captured write data
    output logic write_low_out,                           // Low byte write
    output logic write_high_out,                          // High byte write
    output logic read_out,                                // Read cycle active
    output logic code_fetch_out,                          // Instruction fetch cycle
    output logic memory_enable_out,                       // Memories enabled
    output logic device_init_out,                         // Ports, cells, regs held
    output logic flash_abort_out                          // Abort flash operation
);

    typedef struct packed {
        host_mode_t host_mode_ff;
        third_mode_t third_mode_ff;
        logic bus16_ff;
        logic edge_latch_ff;
        logic cs_used_ff;
        logic high_write_used_ff;
        logic pin_reset_ff;
        logic [BYTE_W-1:0] lower_out_ff;
        logic [BYTE_W-1:0] upper_out_ff;
        logic lower_oe_n_ff;
        logic upper_oe_n_ff;
        logic [DATA_W-1:0] pla_addr_ff;
        logic [CTRL_W-1:0] pla_ctrl_ff;
        logic [DATA_W-1:0] write_data_ff;
        logic write_low_ff;
        logic write_high_ff;
        logic read_ff;
        logic code_fetch_ff;
        logic mem_enable_ff;
        logic init_ff;
        logic abort_ff;
    } port_state_t;

    port_state_t state_ff;
    port_state_t nxt_state;

    logic [DATA_W-1:0] port_addr;
    logic [DATA_W-1:0] held_addr;
    logic in_reset;

    // Byte-lane enables from the third control and the lane address bit
    function automatic logic [1:0] lane_enables(
        input logic bus16,
        input third_mode_t mode,
        input logic third,
        input logic lane_bit
    );
        logic [1:0] lanes;
        lanes = 2'b01;
        if (bus16)
        begin
            unique case (mode)
                THIRD_HIGH_ENABLE:
                begin
                    lanes = {!third, !lane_bit};
                end
                THIRD_HIGH_STROBE:
                begin
                    lanes = {!third, 1'b1};
                end
                THIRD_SIZE_ENABLE:
                begin
                    lanes = {lane_bit || !third, !lane_bit || !third};
                end
                THIRD_LOW_STROBE:
                begin
                    lanes = {!lane_bit, !third};
                end
                THIRD_CODE_FETCH:
                begin
                    lanes = 2'b11;
                end
                default:
                begin
                    lanes = 2'b00;
                end
            endcase
        end
        return lanes;
    endfunction

    assign port_addr = {upper_addr_data_port_in, lower_addr_data_port_in};

    addr_hold #(
        .WIDTH(DATA_W)
    ) u_addr_hold (
        .clk_in(clk_in),
        .sys_rst_in(in_reset),
        .strobe_in(address_strobe_in),
        .edge_mode_in(state_ff.edge_latch_ff),
        .addr_in(port_addr),
        .addr_out(held_addr)
    );

    assign in_reset = sys_rst_in || !reset_n_in;

    always_comb
    begin
        logic first;
        logic second;
        logic third;
        logic rd_cyc;
        logic wr_low_cyc;
        logic wr_high_cyc;
        logic cs_ok;
        logic drive;
        logic [1:0] lanes;
        first = control_input_first_in;
        second = control_input_second_in;
        third = control_input_third_in;
        rd_cyc = 1'b0;
        wr_low_cyc = 1'b0;
        wr_high_cyc = 1'b0;
        cs_ok = 1'b0;
        drive = 1'b0;
        nxt_state = state_ff;

        lanes = lane_enables(state_ff.bus16_ff, state_ff.third_mode_ff, third,
                             held_addr[LANE_ADDR_BIT]);

        unique case (state_ff.host_mode_ff)
            HOST_WR_RD:
            begin
                wr_low_cyc = !first;
                rd_cyc = !second;
            end
            HOST_RW_E:
            begin
                rd_cyc = first && second;
                wr_low_cyc = !first && second;
            end
            HOST_RW_DS:
            begin
                rd_cyc = first && !second;
                wr_low_cyc = !first && !second;
            end
            HOST_SPLIT:
            begin
                wr_low_cyc = !first;
                rd_cyc = !second;
                lanes[0] = !first || !second;
                if (state_ff.third_mode_ff != THIRD_HIGH_STROBE)
                begin
                    lanes[1] = 1'b0;
                end
            end
        endcase

        if (state_ff.host_mode_ff == HOST_SPLIT)
        begin
            // Each byte has its own write strobe here
            wr_high_cyc = state_ff.bus16_ff && state_ff.high_write_used_ff
                          && !high_byte_write_n_in;
            if (wr_high_cyc)
            begin
                lanes[1] = 1'b1;
            end
        end
        else
        begin
            wr_high_cyc = wr_low_cyc;
        end

        // Memories shut while chip select is high
        cs_ok = !state_ff.cs_used_ff || !chip_select_n_in;

        // No write strobe without its own lane; reads ignore the lanes
        nxt_state.write_low_ff = wr_low_cyc && lanes[0] && cs_ok;
        nxt_state.write_high_ff = wr_high_cyc && lanes[1] && cs_ok
                                  && state_ff.bus16_ff;
        nxt_state.read_ff = rd_cyc && cs_ok;
        nxt_state.code_fetch_ff = (state_ff.third_mode_ff == THIRD_CODE_FETCH)
                                  && !third;
        nxt_state.mem_enable_ff = cs_ok;

        // Drive only on a read that hits an internal block
        drive = rd_cyc && cs_ok && block_selected_in;
        nxt_state.lower_oe_n_ff = !(drive && lanes[0]);
        nxt_state.upper_oe_n_ff = !(drive && lanes[1] && state_ff.bus16_ff);
        nxt_state.lower_out_ff = read_data_in[BYTE_W-1:0];
        nxt_state.upper_out_ff = read_data_in[DATA_W-1:BYTE_W];

        if (wr_low_cyc && lanes[0])
        begin
            nxt_state.write_data_ff[BYTE_W-1:0] = lower_addr_data_port_in;
        end
        if (wr_high_cyc && lanes[1])
        begin
            nxt_state.write_data_ff[DATA_W-1:BYTE_W] = upper_addr_data_port_in;
        end

        // Raw pins into the logic arrays in every mode
        nxt_state.pla_addr_ff = port_addr;
        nxt_state.pla_ctrl_ff = {third, second, first};

        nxt_state.pin_reset_ff = !reset_n_in;
        nxt_state.init_ff = 1'b0;
        nxt_state.abort_ff = 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || !reset_n_in)
        begin
            // Pin functions come from the stored configuration
            state_ff.host_mode_ff <= cfg_host_mode_in;
            state_ff.third_mode_ff <= cfg_third_mode_in;
            state_ff.bus16_ff <= cfg_bus16_in;
            state_ff.edge_latch_ff <= cfg_edge_latch_in;
            state_ff.cs_used_ff <= cfg_cs_used_in;
            state_ff.high_write_used_ff <= cfg_high_write_used_in;
            state_ff.pin_reset_ff <= !reset_n_in;
            state_ff.lower_out_ff <= DATA_RST[BYTE_W-1:0];
            state_ff.upper_out_ff <= DATA_RST[BYTE_W-1:0];
            state_ff.lower_oe_n_ff <= 1'b1;
            state_ff.upper_oe_n_ff <= 1'b1;
            state_ff.pla_addr_ff <= DATA_W'(ADDR_RST);
            state_ff.pla_ctrl_ff <= CTRL_RST;
            state_ff.write_data_ff <= DATA_W'(DATA_RST);
            state_ff.write_low_ff <= STROBE_RST;
            state_ff.write_high_ff <= STROBE_RST;
            state_ff.read_ff <= STROBE_RST;
            state_ff.code_fetch_ff <= STROBE_RST;
            state_ff.mem_enable_ff <= STROBE_RST;
            state_ff.init_ff <= !reset_n_in;
            // One pulse on the pin's falling edge
            state_ff.abort_ff <= !reset_n_in && !state_ff.pin_reset_ff;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign lower_addr_data_port_out = state_ff.lower_out_ff;
    assign upper_addr_data_port_out = state_ff.upper_out_ff;
    assign lower_addr_data_port_oe_n_out = state_ff.lower_oe_n_ff;
    assign upper_addr_data_port_oe_n_out = state_ff.upper_oe_n_ff;
    assign latched_addr_out = held_addr;
    assign pla_addr_out = state_ff.pla_addr_ff;
    assign pla_ctrl_out = state_ff.pla_ctrl_ff;
    assign write_data_out = state_ff.write_data_ff;
    assign write_low_out = state_ff.write_low_ff;
    assign write_high_out = state_ff.write_high_ff;
    assign read_out = state_ff.read_ff;
    assign code_fetch_out = state_ff.code_fetch_ff;
    assign memory_enable_out = state_ff.mem_enable_ff;
    assign device_init_out = state_ff.init_ff;
    assign flash_abort_out = state_ff.abort_ff;

endmodule

//--- host_port_pkg.sv
package host_port_pkg;

    // Width of one address/data port, of the whole bus and of the control inputs
    localparam int BYTE_W = 8;
    localparam int BUS_W = 16;
    localparam int CTRL_W = 3;

    // Index of the address bit that picks the byte lane
    localparam int LANE_ADDR_BIT = 0;

    // Values after reset
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [2:0] CTRL_RST = 3'h7;
    localparam logic STROBE_RST = 1'b0;

    // Length of the abort pulse to the flash controller, in cycles
    localparam int ABORT_PULSE_CYC = 1;

    // Meaning of the first and second control inputs
    typedef enum logic [1:0] {
        HOST_WR_RD,
        HOST_RW_E,
        HOST_RW_DS,
        HOST_SPLIT
    } host_mode_t;

    // Meaning of the third control input
    typedef enum logic [2:0] {
        THIRD_CODE_FETCH,
        THIRD_HIGH_ENABLE,
        THIRD_HIGH_STROBE,
        THIRD_SIZE_ENABLE,
        THIRD_LOW_STROBE
    } third_mode_t;

    localparam host_mode_t HOST_MODE_RST = HOST_WR_RD;
    localparam third_mode_t THIRD_MODE_RST = THIRD_HIGH_ENABLE;

endpackage

//--- addr_hold.sv
`timescale 1ns/100ps
module addr_hold
    import host_port_pkg::*;
#(
    parameter int WIDTH = BUS_W
)
(
    input wire logic clk_in,                    // System clock
    input wire logic sys_rst_in,                // Synchronous reset, high
    input wire logic strobe_in,                 // Latch strobe, high active
    input wire logic edge_mode_in,              // 1: capture on rising edge only
    input wire logic [WIDTH-1:0] addr_in,       // Address from both ports
    output logic [WIDTH-1:0] addr_out           // Held address
);

    typedef struct packed {
        logic strobe_ff;
        logic [WIDTH-1:0] addr_ff;
    } hold_state_t;

    hold_state_t state_ff;
    hold_state_t nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.strobe_ff = strobe_in;
        if (edge_mode_in)
        begin
            // Address strobe: take it on the rising edge only
            if (strobe_in && !state_ff.strobe_ff)
            begin
                nxt_state.addr_ff = addr_in;
            end
        end
        else if (strobe_in)
        begin
            // Latch enable: follow while high, freeze on the fall
            nxt_state.addr_ff = addr_in;
        end
        // Otherwise the address stays put until the next strobe
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_ff.strobe_ff <= STROBE_RST;
            state_ff.addr_ff <= WIDTH'(ADDR_RST);
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign addr_out = state_ff.addr_ff;

endmodule

//--- host_port_properties.sv
`timescale 1ns/100ps
module host_port_properties
    import host_port_pkg::*;
#(
    parameter int DATA_W = BUS_W
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic reset_n_in,
    input wire host_mode_t cfg_host_mode_in,
    input wire third_mode_t cfg_third_mode_in,
    input wire logic cfg_edge_latch_in,
    input wire logic cfg_cs_used_in,
    input wire logic [BYTE_W-1:0] lower_addr_data_port_in,
    input wire logic lower_addr_data_port_oe_n_out,
    input wire logic [BYTE_W-1:0] upper_addr_data_port_in,
    input wire logic upper_addr_data_port_oe_n_out,
    input wire logic control_input_first_in,
    input wire logic control_input_second_in,
    input wire logic control_input_third_in,
    input wire logic address_strobe_in,
    input wire logic chip_select_n_in,
    input wire logic block_selected_in,
    input wire logic [DATA_W-1:0] latched_addr_out,
    input wire logic [DATA_W-1:0] pla_addr_out,
    input wire logic [CTRL_W-1:0] pla_ctrl_out,
    input wire logic write_low_out,
    input wire logic read_out,
    input wire logic code_fetch_out,
    input wire logic memory_enable_out,
    input wire logic device_init_out,
    input wire logic flash_abort_out
);
    logic live;
    logic cs_ok;
    logic prev_ok_ff;
    logic [DATA_W-1:0] ports;
    assign live = !sys_rst_in && reset_n_in;
    assign cs_ok = !cfg_cs_used_in || !chip_select_n_in;
    assign ports = {upper_addr_data_port_in, lower_addr_data_port_in};
    // Previous edge was outside any reset
    always_ff @(posedge clk_in)
        prev_ok_ff <= live;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!live);
    AST_PLA_ADDR: assert property (prev_ok_ff |-> pla_addr_out == $past(ports))
        else $error("Array address does not follow the ports");
    AST_PLA_CTRL: assert property (prev_ok_ff |-> pla_ctrl_out ==
        $past({control_input_third_in, control_input_second_in, control_input_first_in}))
        else $error("Array controls do not follow the pins");
    AST_ALE_FOLLOW: assert property (prev_ok_ff && !cfg_edge_latch_in &&
        $past(address_strobe_in) |-> latched_addr_out == $past(ports))
        else $error("Transparent latch missed the address");
    AST_AS_RISE: assert property (prev_ok_ff && $past(prev_ok_ff) && cfg_edge_latch_in &&
        $past(address_strobe_in) && !$past(address_strobe_in, 2) |->
        latched_addr_out == $past(ports))
        else $error("Edge latch missed the address");
    AST_HOLD: assert property (prev_ok_ff && $past(prev_ok_ff) &&
        (!$past(address_strobe_in) || cfg_edge_latch_in && $past(address_strobe_in, 2))
        |-> $stable(latched_addr_out))
        else $error("Held address changed without a latch");
    AST_DRIVE_GATE: assert property (!lower_addr_data_port_oe_n_out ||
        !upper_addr_data_port_oe_n_out |-> read_out && $past(block_selected_in && cs_ok))
        else $error("Ports driven outside a selected read");
    AST_READ_DECODE: assert property (prev_ok_ff && cfg_host_mode_in == HOST_WR_RD |->
        read_out == $past(!control_input_second_in && cs_ok))
        else $error("Read strobe decode wrong");
    AST_DIR_DECODE: assert property (prev_ok_ff && cfg_host_mode_in == HOST_RW_DS |->
        read_out == $past(control_input_first_in && !control_input_second_in && cs_ok))
        else $error("Direction decode wrong");
    AST_WRITE_STROBE: assert property (write_low_out |-> !$past(control_input_first_in))
        else $error("Low write without first control low");
    AST_CS_BLOCK: assert property (prev_ok_ff && !$past(cs_ok) |->
        !memory_enable_out && !read_out && !write_low_out)
        else $error("Access while chip select high");
    AST_FETCH: assert property (prev_ok_ff && cfg_third_mode_in == THIRD_CODE_FETCH &&
        $past(cs_ok) |-> code_fetch_out == !$past(control_input_third_in))
        else $error("Code fetch flag wrong");
    AST_ABORT: assert property (disable iff (sys_rst_in) !$past(sys_rst_in) &&
        $past(reset_n_in, 2) && !$past(reset_n_in) |-> flash_abort_out ##1 !flash_abort_out)
        else $error("Flash abort pulse wrong");
    AST_INIT: assert property (disable iff (sys_rst_in)
        !$past(sys_rst_in) && !$past(reset_n_in) |-> device_init_out)
        else $error("Init not held during reset pin");
endmodule
bind host_port host_port_properties #(.DATA_W(DATA_W)) props (.clk_in, .sys_rst_in, .reset_n_in,
    .cfg_host_mode_in, .cfg_third_mode_in, .cfg_edge_latch_in, .cfg_cs_used_in,
    .lower_addr_data_port_in, .lower_addr_data_port_oe_n_out, .upper_addr_data_port_in,
    .upper_addr_data_port_oe_n_out, .control_input_first_in, .control_input_second_in,
    .control_input_third_in, .address_strobe_in, .chip_select_n_in, .block_selected_in,
    .latched_addr_out, .pla_addr_out, .pla_ctrl_out, .write_low_out, .read_out,
    .code_fetch_out, .memory_enable_out, .device_init_out, .flash_abort_out);

//--- mcu_host_model.sv
`timescale 1ns/100ps
module mcu_host_model
(
    input wire logic clk_in,                // System clock
    input wire logic [15:0] dev_data_in,    // Device drive {upper,lower}
    input wire logic lo_oe_n_in,            // Lower enable, low
    input wire logic hi_oe_n_in,            // Upper enable, low
    output logic [15:0] pins_out,           // Resolved port levels
    output logic [2:0] ctrl_out,            // {third,second,first}
    output logic strobe_out,                // Address latch strobe
    output logic reset_n_out                // Device reset pin
);
    logic [15:0] drv;
    logic [15:0] last;
    logic released;
    // Released lines show the inverse of the last value
    assign pins_out[7:0] = !lo_oe_n_in ? dev_data_in[7:0] : released ? ~last[7:0] : drv[7:0];
    assign pins_out[15:8] = !hi_oe_n_in ? dev_data_in[15:8] : released ? ~last[15:8] : drv[15:8];
    initial
    begin
        drv = 16'h0000;
        last = 16'h0000;
        released = 1'b1;
        ctrl_out = 3'h7;
        strobe_out = 1'b0;
        reset_n_out = 1'b0;
    end
    task automatic drive(input logic [15:0] v);
        drv = v;
        last = v;
        released = 1'b0;
    endtask
    // Strobe high for n cycles; address flips after the first
    task automatic latch(input logic [15:0] a, input int n);
        @(negedge clk_in);
        drive(a);
        strobe_out = 1'b1;
        repeat (n - 1)
        begin
            @(negedge clk_in);
            drive(~a);
        end
        @(negedge clk_in);
        strobe_out = 1'b0;
    endtask
    task automatic pins(input logic [2:0] c, input logic rel);
        @(negedge clk_in);
        ctrl_out = c;
        released = rel;
    endtask
    task automatic read(output logic [15:0] d);
        pins(3'h1, 1'b1);
        @(negedge clk_in);
        d = pins_out;
        ctrl_out = 3'h7;
    endtask
    task automatic write(input logic [15:0] d);
        @(negedge clk_in);
        drive(d);
        ctrl_out = 3'h2;
        @(negedge clk_in);
        ctrl_out = 3'h7;
        released = 1'b1;
    endtask
    task automatic set_reset(input logic v);
        @(negedge clk_in);
        reset_n_out = v;
    endtask
endmodule

//--- host_port_test.sv
`timescale 1ns/100ps
module host_port_test
    import host_port_pkg::*;
;
    typedef struct {host_mode_t hm; third_mode_t tm; logic a0; logic cs_n; logic sel;
        logic [2:0] c; logic [5:0] exp;} row_t;
    logic clk_in, sys_rst_in, reset_n_in, cfg_bus16_in, cfg_edge_latch_in, cfg_cs_used_in;
    logic cfg_high_write_used_in, chip_select_n_in, block_selected_in;
    logic control_input_first_in, control_input_second_in, control_input_third_in;
    logic address_strobe_in, write_low_out, write_high_out, read_out, code_fetch_out;
    logic memory_enable_out, device_init_out, flash_abort_out;
    logic lower_addr_data_port_oe_n_out, upper_addr_data_port_oe_n_out;
    host_mode_t cfg_host_mode_in;
    third_mode_t cfg_third_mode_in;
    logic [7:0] lower_addr_data_port_in, upper_addr_data_port_in;
    logic [7:0] lower_addr_data_port_out, upper_addr_data_port_out;
    logic [15:0] read_data_in, latched_addr_out, pla_addr_out, write_data_out, pins;
    logic [2:0] pla_ctrl_out, ctrl;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    row_t rows[17] = '{
        '{HOST_WR_RD, THIRD_HIGH_ENABLE, 1'b0, 1'b0, 1'b1, 3'h1, 6'h20},
        '{HOST_WR_RD, THIRD_HIGH_ENABLE, 1'b1, 1'b0, 1'b1, 3'h2, 6'h33},
        '{HOST_WR_RD, THIRD_HIGH_ENABLE, 1'b0, 1'b0, 1'b1, 3'h6, 6'h2b},
        '{HOST_WR_RD, THIRD_HIGH_ENABLE, 1'b1, 1'b0, 1'b1, 3'h6, 6'h23},
        '{HOST_RW_E, THIRD_HIGH_ENABLE, 1'b0, 1'b0, 1'b1, 3'h3, 6'h20},
        '{HOST_RW_E, THIRD_HIGH_ENABLE, 1'b0, 1'b0, 1'b1, 3'h2, 6'h3b},
        '{HOST_RW_E, THIRD_HIGH_ENABLE, 1'b0, 1'b0, 1'b1, 3'h0, 6'h23},
        '{HOST_RW_DS, THIRD_HIGH_ENABLE, 1'b0, 1'b0, 1'b1, 3'h1, 6'h20},
        '{HOST_RW_DS, THIRD_HIGH_ENABLE, 1'b0, 1'b0, 1'b1, 3'h0, 6'h3b},
        '{HOST_SPLIT, THIRD_HIGH_STROBE, 1'b0, 1'b0, 1'b1, 3'h1, 6'h20},
        '{HOST_SPLIT, THIRD_HIGH_STROBE, 1'b0, 1'b0, 1'b1, 3'h6, 6'h3b},
        '{HOST_WR_RD, THIRD_CODE_FETCH, 1'b0, 1'b0, 1'b1, 3'h1, 6'h24},
        '{HOST_WR_RD, THIRD_CODE_FETCH, 1'b0, 1'b0, 1'b1, 3'h5, 6'h20},
        '{HOST_WR_RD, THIRD_SIZE_ENABLE, 1'b1, 1'b0, 1'b1, 3'h6, 6'h33},
        '{HOST_WR_RD, THIRD_LOW_STROBE, 1'b0, 1'b0, 1'b1, 3'h2, 6'h3b},
        '{HOST_WR_RD, THIRD_HIGH_ENABLE, 1'b0, 1'b1, 1'b1, 3'h1, 6'h03},
        '{HOST_WR_RD, THIRD_HIGH_ENABLE, 1'b0, 1'b0, 1'b0, 3'h1, 6'h23}};
    host_port dut (.clk_in, .sys_rst_in, .reset_n_in, .cfg_host_mode_in, .cfg_third_mode_in,
        .cfg_bus16_in, .cfg_edge_latch_in, .cfg_cs_used_in, .cfg_high_write_used_in,
        .lower_addr_data_port_in, .lower_addr_data_port_out, .lower_addr_data_port_oe_n_out,
        .upper_addr_data_port_in, .upper_addr_data_port_out, .upper_addr_data_port_oe_n_out,
        .control_input_first_in, .control_input_second_in, .control_input_third_in,
        .address_strobe_in, .chip_select_n_in, .block_selected_in,
        .high_byte_write_n_in(control_input_first_in),
        .read_data_in, .latched_addr_out, .pla_addr_out, .pla_ctrl_out, .write_data_out,
        .write_low_out, .write_high_out, .read_out, .code_fetch_out, .memory_enable_out,
        .device_init_out, .flash_abort_out);
    mcu_host_model host (.clk_in, .dev_data_in({upper_addr_data_port_out, lower_addr_data_port_out}),
        .lo_oe_n_in(lower_addr_data_port_oe_n_out), .hi_oe_n_in(upper_addr_data_port_oe_n_out),
        .pins_out(pins), .ctrl_out(ctrl), .strobe_out(address_strobe_in), .reset_n_out(reset_n_in));
    assign {upper_addr_data_port_in, lower_addr_data_port_in} = pins;
    assign {control_input_third_in, control_input_second_in, control_input_first_in} = ctrl;
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Configuration is taken while sys_rst_in is high or the reset pin is low
    task automatic setup(input host_mode_t hm, input third_mode_t tm, input logic edge_mode);
        @(negedge clk_in);
        cfg_host_mode_in = hm;
        cfg_third_mode_in = tm;
        cfg_edge_latch_in = edge_mode;
        sys_rst_in = 1'b1;
        @(negedge clk_in);
        sys_rst_in = 1'b0;
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            conclude();
        end
    end
    initial
    begin
        logic [15:0] d;
        sys_rst_in = 1'b1;
        cfg_host_mode_in = HOST_WR_RD;
        cfg_third_mode_in = THIRD_HIGH_ENABLE;
        cfg_bus16_in = 1'b1;
        cfg_edge_latch_in = 1'b0;
        cfg_cs_used_in = 1'b1;
        cfg_high_write_used_in = 1'b1;
        chip_select_n_in = 1'b0;
        block_selected_in = 1'b0;
        read_data_in = 16'h9e17;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        host.set_reset(1'b1);
        foreach (rows[i])
        begin
            setup(rows[i].hm, rows[i].tm, 1'b0);
            block_selected_in = 1'b0;
            chip_select_n_in = 1'b0;
            host.latch({15'h2618, rows[i].a0}, 1);
            host.pins(rows[i].c, 1'b0);
            chip_select_n_in = rows[i].cs_n;
            block_selected_in = rows[i].sel;
            @(negedge clk_in);
            check("lanes", {10'h000, memory_enable_out, write_high_out, write_low_out, code_fetch_out,
                upper_addr_data_port_oe_n_out, lower_addr_data_port_oe_n_out},
                {10'h000, rows[i].exp});
            host.pins(3'h7, 1'b1);
        end
        setup(HOST_WR_RD, THIRD_HIGH_ENABLE, 1'b0);
        chip_select_n_in = 1'b0;
        block_selected_in = 1'b1;
        host.latch(16'h1234, 1);
        host.read(d);
        check("read data", d, 16'h9e17);
        check("latched", latched_addr_out, 16'h1234);
        host.write(16'h5aa5);
        check("write data", write_data_out, 16'h5aa5);
        for (int e = 0; e < 2; e++)
        begin
            setup(HOST_WR_RD, THIRD_HIGH_ENABLE, e[0]);
            host.latch(16'h00f0, 2);
            @(negedge clk_in);
            check("latched", latched_addr_out, e ? 16'h00f0 : 16'hff0f);
        end
        host.set_reset(1'b0);
        @(negedge clk_in);
        check("abort", {15'h0000, flash_abort_out}, 16'h0001);
        check("init", {15'h0000, device_init_out}, 16'h0001);
        @(negedge clk_in);
        check("abort", {15'h0000, flash_abort_out}, 16'h0000);
        check("port enable", {15'h0000, lower_addr_data_port_oe_n_out}, 16'h0001);
        host.set_reset(1'b1);
        conclude();
    end
endmodule
